// ### inc/ipc_params.svh
// Offsets, field positions, reset values and timing counts of the carrier bridge.
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH
`define IPC_OFF_CTRL 8'h00
`define IPC_OFF_STAT 8'h04
`define IPC_OFF_MASK 8'h08
`define IPC_OFF_PEND 8'h0c
`define IPC_OFF_IRQEN 8'h10
`define IPC_OFF_INFO 8'h14
`define IPC_CTRL_GIE 0
`define IPC_CTRL_CLK 8
`define IPC_EV_TMO 0
`define IPC_EV_RDY 1
`define IPC_INFO_NSLOT 8
`define IPC_MASK_RST 2'h0
`define IPC_RD_ONES 32'hffff_ffff
`define IPC_CLK_NS 10
`define IPC_SYS_MHZ 100
`define IPC_FAST_MHZ 32
`define IPC_SLOW_MHZ 8
`define IPC_TMO_NS 32000
`define IPC_TMO_CYC (`IPC_TMO_NS / `IPC_CLK_NS)
`define IPC_MRST_CYC 16
`define IPC_BAR_BYTES 32'h0400_0000
`endif

// ### inc/ipc_pkg.sv
// Types shared by the carrier bridge modules.
package ipc_pkg;
  typedef enum logic [1:0] {SP_IO = 2'h0, SP_ID = 2'h1, SP_INT = 2'h2, SP_MEM = 2'h3} ipc_space_t;
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_RD = 4'h2, ST_WR = 4'h4, ST_HOLD = 4'h8} ipc_state_t;
endpackage

// ### inc/ipc_mod_if.sv
// Request and answer between the host side and the module cycle engine.
`timescale 1ns/1ps
interface ipc_mod_if;
  logic start;
  logic wr;
  logic [2:0] slot;
  ipc_pkg::ipc_space_t space;
  logic [22:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic done;
  logic tmo;
  logic busy;
  logic [31:0] rdata;
  modport master (output start, wr, slot, space, addr, be, wdata, input done, tmo, busy, rdata);
  modport engine (input start, wr, slot, space, addr, be, wdata, output done, tmo, busy, rdata);
endinterface

// ### hdl/ipc_clk_gen.sv
// Per-slot module clock made from the system clock by a phase accumulator.
`timescale 1ns/1ps
`include "ipc_params.svh"
module ipc_clk_gen #(
  parameter int NSLOT = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Speed select, one picks the fast clock
  input wire logic [NSLOT-1:0] fast,
  // Module clocks
  output logic [NSLOT-1:0] mod_clk
);
  localparam logic [8:0] MODV = 9'(`IPC_SYS_MHZ);
  logic [7:0] acc_ff [NSLOT];
  logic [NSLOT-1:0] clk_ff;

  // Two half periods per module clock period, so the step is twice the rate.
  function automatic logic [8:0] sum_of(input logic [7:0] acc, input logic f);
    sum_of = {1'b0, acc} + (f ? 9'(2 * `IPC_FAST_MHZ) : 9'(2 * `IPC_SLOW_MHZ));
  endfunction

  // The edges jitter by one system cycle; modules see the right mean rate.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NSLOT; i++) acc_ff[i] <= 8'h00;
      clk_ff <= '0;
    end else begin
      for (int i = 0; i < NSLOT; i++) begin
        if (sum_of(acc_ff[i], fast[i]) >= MODV) begin
          acc_ff[i] <= 8'(sum_of(acc_ff[i], fast[i]) - MODV);
          clk_ff[i] <= ~clk_ff[i];
        end else begin
          acc_ff[i] <= 8'(sum_of(acc_ff[i], fast[i]));
        end
      end
    end
  end

  assign mod_clk = clk_ff;
endmodule

// ### hdl/ipc_mod_cycle.sv
// Module access engine: one cycle on a slot, ended by acknowledge or time-out.
`timescale 1ns/1ps
`include "ipc_params.svh"
module ipc_mod_cycle #(
  parameter int NSLOT = 5,
  parameter int TMO_CYC = `IPC_TMO_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request from the host side
  ipc_mod_if.engine req,
  // Module bus
  output logic [NSLOT-1:0] mod_sel,
  output logic [1:0] mod_space,
  output logic [22:0] mod_addr,
  output logic [3:0] mod_be,
  output logic mod_wr,
  output logic [31:0] mod_wdata,
  input wire logic [NSLOT-1:0] mod_ack,
  input wire logic [31:0] mod_rdata
);
  localparam int CW = $clog2(TMO_CYC + 1);
  logic [NSLOT-1:0] sel_ff;
  logic [1:0] space_ff;
  logic [22:0] addr_ff;
  logic [3:0] be_ff;
  logic wr_ff;
  logic [31:0] wd_ff;
  logic [CW-1:0] cnt_ff;
  logic done_ff;
  logic tmo_ff;
  logic [31:0] rd_ff;

  wire logic busy = |sel_ff;
  wire logic ack_hit = |(mod_ack & sel_ff);
  wire logic expire = cnt_ff == CW'(TMO_CYC - 1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_ff <= '0;
      space_ff <= 2'h0;
      addr_ff <= 23'h000000;
      be_ff <= 4'h0;
      wr_ff <= 1'b0;
      wd_ff <= 32'h0000_0000;
      cnt_ff <= '0;
      done_ff <= 1'b0;
      tmo_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
    end else begin
      done_ff <= 1'b0;
      if (!busy && req.start) begin
        sel_ff <= NSLOT'(1) << req.slot;
        space_ff <= req.space;
        addr_ff <= req.addr;
        be_ff <= req.be;
        wr_ff <= req.wr;
        wd_ff <= req.wdata;
        cnt_ff <= '0;
      end else if (busy) begin
        cnt_ff <= cnt_ff + CW'(1);
        if (ack_hit) begin
          sel_ff <= '0;
          done_ff <= 1'b1;
          tmo_ff <= 1'b0;
          rd_ff <= mod_rdata;
        end else if (expire) begin
          sel_ff <= '0;
          done_ff <= 1'b1;
          tmo_ff <= 1'b1;
          rd_ff <= `IPC_RD_ONES;
        end
      end
    end
  end

  assign req.done = done_ff;
  assign req.tmo = tmo_ff;
  assign req.busy = busy;
  assign req.rdata = rd_ff;
  assign mod_sel = sel_ff;
  assign mod_space = space_ff;
  assign mod_addr = addr_ff;
  assign mod_be = be_ff;
  assign mod_wr = wr_ff;
  assign mod_wdata = wd_ff;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  tmo_bound_a: assert property (busy |-> cnt_ff < CW'(TMO_CYC))
    else $error("module cycle ran past the time-out");
  tmo_end_a: assert property ((busy && !ack_hit && expire) |=> done_ff && tmo_ff && !busy)
    else $error("time-out did not end the module cycle");
  one_slot_a: assert property ($onehot0(sel_ff))
    else $error("more than one slot selected");
endmodule

// ### hdl/ipc_bridge.sv
// Carrier bridge top: host target port, module slots, interrupts and APB registers.
//
// What this block does
// - Answer the host bus only as a target, never mastering it.
// - Each host transfer is one data phase of 8, 16 or 32 bits.
// - A host read is disconnected at once; the fetch runs behind it.
// - Fetched data waits in the read buffer until the host repeats the read.
// - A module silent for 32 us ends the host access normally.
// - A time-out sets a status flag that can raise the interrupt.
// - Module cycles reach I/O, interrupt, ID and memory space of each slot.
// - Two interrupt lines per slot, each with its own enable and pending bit.
// - Every enabled module interrupt drives the shared host interrupt while the global enable bit of CTRL is set.
// - A pending register shows which module interrupts are active.
// - Software picks 8 or 32 MHz for each slot clock.
// - Slot count is a build parameter, five or three.
// - Module reset follows power-up, power loss and low supply.
// - A strap enables 8 MB memory per slot inside a fixed 64 MB window.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "ipc_params.svh"
module ipc_bridge #(
  parameter int NSLOT = 5,
  parameter int TMO_CYC = `IPC_TMO_CYC,
  parameter int MRST_CYC = `IPC_MRST_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host target port
  input wire logic hst_req,
  input wire logic hst_wr,
  input wire logic hst_bar,
  input wire logic [25:0] hst_addr,
  input wire logic [3:0] hst_be,
  input wire logic [31:0] hst_wdata,
  output logic hst_done,
  output logic hst_retry,
  output logic [31:0] hst_rdata,
  // Host interrupt, open drain
  output logic inta_o,
  output logic inta_oe_n,
  // Module bus
  output logic [NSLOT-1:0] mod_sel,
  output logic [1:0] mod_space,
  output logic [22:0] mod_addr,
  output logic [3:0] mod_be,
  output logic mod_wr,
  output logic [31:0] mod_wdata,
  input wire logic [NSLOT-1:0] mod_ack,
  input wire logic [31:0] mod_rdata,
  // Module clocks, reset and interrupts
  output logic [NSLOT-1:0] mod_clk,
  output logic mod_rst_n,
  input wire logic [2*NSLOT-1:0] mod_irq_n,
  // Supervisor and strap
  input wire logic pwr_ok,
  input wire logic strap_mem_en
);
  localparam int RCW = $clog2(MRST_CYC + 1);

  ipc_mod_if bus ();
  ipc_pkg::ipc_state_t st_ff;
  ipc_pkg::ipc_state_t nxt_st;
  logic [31:0] fifo_ff;
  logic [30:0] key_ff;
  logic mem_en_ff;
  logic strap_done_ff;
  logic gie_ff;
  logic [NSLOT-1:0] fast_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic [2*NSLOT-1:0] irqen_ff;
  logic irq_ff;
  logic [RCW-1:0] mrst_cnt_ff;
  logic mrst_n_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_val;

  // ==========================================================
  // Host address decode
  // ==========================================================

  // Only single data phases on naturally aligned lanes are accepted.
  function automatic logic be_ok(input logic [3:0] be);
    case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_ok = 1'b1;
      default: be_ok = 1'b0;
    endcase
  endfunction

  wire logic [2:0] dec_slot = hst_bar ? hst_addr[25:23] : hst_addr[10:8];
  wire ipc_pkg::ipc_space_t dec_space = hst_bar ? ipc_pkg::SP_MEM
                                                : ipc_pkg::ipc_space_t'(hst_addr[7:6]);
  wire logic [22:0] dec_off = hst_bar ? hst_addr[22:0] : {17'h00000, hst_addr[5:0]};
  wire logic bad_slot = dec_slot >= 3'(NSLOT);
  wire logic bad_mem = hst_bar && !mem_en_ff;
  wire logic bad_io = !hst_bar && dec_space == ipc_pkg::SP_MEM;
  wire logic dummy = !be_ok(hst_be) || bad_slot || bad_mem || bad_io;
  wire logic [30:0] key_now = {hst_bar, hst_addr, hst_be};
  wire logic key_hit = key_now == key_ff;

  // ==========================================================
  // Host target sequencer
  // ==========================================================

  wire logic is_idle = st_ff == ipc_pkg::ST_IDLE;
  wire logic is_rd = st_ff == ipc_pkg::ST_RD;
  wire logic is_wr = st_ff == ipc_pkg::ST_WR;
  wire logic is_hold = st_ff == ipc_pkg::ST_HOLD;
  wire logic rd_req = hst_req && !hst_wr;
  wire logic wr_req = hst_req && hst_wr;
  wire logic take_rd = is_idle && rd_req;
  wire logic take_wr = is_idle && wr_req && !dummy;
  wire logic give_rd = is_hold && rd_req && key_hit;

  // Writes hold the host until the module answers; reads never do.
  // A write arriving while a read is parked is retried, so the parked
  // data is not lost before the host comes back for it.
  assign hst_retry = (rd_req && (is_idle || is_rd || (is_hold && !key_hit)))
                     || (wr_req && (is_rd || is_hold));
  assign hst_done = give_rd
                    || (wr_req && is_idle && dummy)
                    || (wr_req && is_wr && bus.done);
  assign hst_rdata = fifo_ff;

  assign bus.start = (take_rd && !dummy) || take_wr;
  assign bus.wr = hst_wr;
  assign bus.slot = dec_slot;
  assign bus.space = dec_space;
  assign bus.addr = dec_off;
  assign bus.be = hst_be;
  assign bus.wdata = hst_wdata;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ipc_pkg::ST_IDLE: begin
        if (take_rd) begin
          nxt_st = dummy ? ipc_pkg::ST_HOLD : ipc_pkg::ST_RD;
        end else if (take_wr) begin
          nxt_st = ipc_pkg::ST_WR;
        end
      end
      ipc_pkg::ST_RD: begin
        if (bus.done) begin
          nxt_st = ipc_pkg::ST_HOLD;
        end
      end
      ipc_pkg::ST_WR: begin
        if (bus.done) begin
          nxt_st = ipc_pkg::ST_IDLE;
        end
      end
      ipc_pkg::ST_HOLD: begin
        if (give_rd) begin
          nxt_st = ipc_pkg::ST_IDLE;
        end
      end
      default: nxt_st = ipc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= ipc_pkg::ST_IDLE;
      key_ff <= 31'h0000_0000;
      fifo_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      if (take_rd) begin
        key_ff <= key_now;
      end
      if (take_rd && dummy) begin
        fifo_ff <= `IPC_RD_ONES;
      end else if (is_rd && bus.done) begin
        fifo_ff <= bus.rdata;
      end
    end
  end

  ipc_mod_cycle #(.NSLOT(NSLOT), .TMO_CYC(TMO_CYC)) u_cycle (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(bus.engine),
    .mod_sel(mod_sel),
    .mod_space(mod_space),
    .mod_addr(mod_addr),
    .mod_be(mod_be),
    .mod_wr(mod_wr),
    .mod_wdata(mod_wdata),
    .mod_ack(mod_ack),
    .mod_rdata(mod_rdata)
  );

  ipc_clk_gen #(.NSLOT(NSLOT)) u_clk (
    .clk_sys(clk_sys),
    .rst(rst),
    .fast(fast_ff),
    .mod_clk(mod_clk)
  );

  // ==========================================================
  // Module reset and memory strap
  // ==========================================================

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mrst_cnt_ff <= '0;
      mrst_n_ff <= 1'b0;
    end else if (!pwr_ok) begin
      mrst_cnt_ff <= '0;
      mrst_n_ff <= 1'b0;
    end else if (mrst_cnt_ff != RCW'(MRST_CYC - 1)) begin
      mrst_cnt_ff <= mrst_cnt_ff + RCW'(1);
    end else begin
      mrst_n_ff <= 1'b1;
    end
  end
  assign mod_rst_n = mrst_n_ff;

  // The strap is sampled once on the first edge after reset release.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_done_ff <= 1'b0;
      mem_en_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      mem_en_ff <= strap_mem_en;
    end
  end

  // ==========================================================
  // Register bus
  // ==========================================================

  wire logic apb_setup = psel && !penable;
  wire logic apb_wr = psel && penable && pwrite;
  wire logic reg_hit = paddr == `IPC_OFF_CTRL || paddr == `IPC_OFF_STAT
                       || paddr == `IPC_OFF_MASK || paddr == `IPC_OFF_PEND
                       || paddr == `IPC_OFF_IRQEN || paddr == `IPC_OFF_INFO;
  wire logic [2*NSLOT-1:0] pend_w = ~mod_irq_n;
  wire logic [1:0] ev = {is_rd && bus.done, bus.done && bus.tmo};
  wire logic [1:0] w1c = (apb_wr && paddr == `IPC_OFF_STAT) ? pwdata[1:0] : 2'h0;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit;
  assign prdata = prdata_ff;

  always_comb begin
    case (paddr)
      `IPC_OFF_CTRL: rd_val = {{(24 - NSLOT){1'b0}}, fast_ff, 7'h00, gie_ff};
      `IPC_OFF_STAT: rd_val = {30'h0000_0000, stat_ff};
      `IPC_OFF_MASK: rd_val = {30'h0000_0000, mask_ff};
      `IPC_OFF_PEND: rd_val = 32'(pend_w);
      `IPC_OFF_IRQEN: rd_val = 32'(irqen_ff);
      `IPC_OFF_INFO: rd_val = {20'h00000, 4'(NSLOT), 6'h00, bus.busy, mem_en_ff};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
      gie_ff <= 1'b0;
      fast_ff <= '0;
      mask_ff <= `IPC_MASK_RST;
      irqen_ff <= '0;
    end else begin
      if (apb_setup && !pwrite) begin
        prdata_ff <= rd_val;
      end
      if (apb_wr && paddr == `IPC_OFF_CTRL) begin
        gie_ff <= pwdata[`IPC_CTRL_GIE];
        fast_ff <= pwdata[`IPC_CTRL_CLK +: NSLOT];
      end
      if (apb_wr && paddr == `IPC_OFF_MASK) begin
        mask_ff <= pwdata[1:0];
      end
      if (apb_wr && paddr == `IPC_OFF_IRQEN) begin
        irqen_ff <= pwdata[2*NSLOT-1:0];
      end
    end
  end

  // ==========================================================
  // Interrupts
  // ==========================================================

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~w1c) | ev;
      irq_ff <= (gie_ff && |(pend_w & irqen_ff)) || |(stat_ff & mask_ff);
    end
  end

  assign inta_o = 1'b0;
  assign inta_oe_n = ~irq_ff;

  // ==========================================================
  // Checks
  // ==========================================================

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_fetched;
    is_rd && bus.done ##1 is_hold;
  endsequence

  sequence s_collect;
    is_hold && rd_req && key_hit;
  endsequence

  rd_disconnect_a: assert property (take_rd |-> hst_retry && !hst_done)
    else $error("read was not disconnected at once");
  no_stale_a: assert property ((is_rd && rd_req) |-> hst_retry && !hst_done)
    else $error("read completed before data was fetched");
  fifo_fill_a: assert property (s_fetched |-> fifo_ff == $past(bus.rdata))
    else $error("fetched data not parked in the read buffer");
  fifo_give_a: assert property (s_collect |-> hst_done && hst_rdata == fifo_ff ##1 is_idle)
    else $error("repeated read did not collect the parked data");
  one_phase_a: assert property ((hst_done || hst_retry) |-> hst_req && !(hst_done && hst_retry))
    else $error("host answer without request or with two answers");
  tmo_flag_a: assert property ((bus.done && bus.tmo) |=> stat_ff[`IPC_EV_TMO])
    else $error("time-out did not set its status flag");
  inta_drive_a: assert property ((gie_ff && |(pend_w & irqen_ff)) |=> !inta_oe_n)
    else $error("enabled module interrupt not driven to the host");
  mod_reset_a: assert property (!pwr_ok |=> !mod_rst_n [*2])
    else $error("module reset released during low supply");
  mem_strap_a: assert property ((wr_req && is_idle && bad_mem) |-> hst_done && !bus.start)
    else $error("memory space used while the strap disables it");
endmodule

// ### verif/ipc_mod_model.sv
// Behavioural model of the fitted mezzanine modules on the module bus.
`timescale 1ns/1ps
module ipc_mod_model #(
  parameter int NSLOT = 5,
  parameter logic [7:0] FITTED = 8'h0f,
  parameter int SLOW_DLY = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Module bus
  input wire logic [NSLOT-1:0] mod_sel,
  input wire logic [1:0] mod_space,
  output logic [NSLOT-1:0] mod_ack,
  output logic [31:0] mod_rdata
);
  logic [7:0] wait_ff;
  logic done_ff;
  logic [2:0] idx;
  logic [31:0] pat;
  always_comb begin
    idx = 3'h0;
    for (int i = 0; i < NSLOT; i++) begin
      if (mod_sel[i]) begin
        idx = i[2:0];
      end
    end
  end
  // Slot zero answers at once, the others slowly; an empty slot never answers.
  assign pat = {24'hc0de00, 2'h0, mod_space, 1'b0, idx};
  // Outside the acknowledge cycle the data lines carry junk, never the answer.
  assign mod_rdata = (|mod_ack) ? pat : ~pat;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_ff <= 8'h0;
      done_ff <= 1'b0;
      mod_ack <= '0;
    end else begin
      mod_ack <= '0;
      if (mod_sel == '0) begin
        wait_ff <= 8'h0;
        done_ff <= 1'b0;
      end else if (!done_ff && FITTED[idx]) begin
        if (wait_ff >= ((idx == 3'h0) ? 8'h0 : SLOW_DLY[7:0])) begin
          mod_ack <= mod_sel;
          done_ff <= 1'b1;
        end else begin
          wait_ff <= wait_ff + 8'h1;
        end
      end
    end
  end
endmodule

// ### verif/tb_pci_ip_carrier_bridge.sv
// Self-checking bench of the carrier bridge.
`timescale 1ns/1ps
module tb_pci_ip_carrier_bridge;
  localparam int NS = 5;
  localparam int MRST = 4;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, hst_wdata, hst_rdata, mod_wdata, mod_rdata;
  logic hst_req, hst_wr, hst_bar, hst_done, hst_retry, inta_o, inta_oe_n;
  logic [25:0] hst_addr;
  logic [3:0] hst_be, mod_be;
  logic [NS-1:0] mod_sel, mod_ack, mod_clk;
  logic [1:0] mod_space;
  logic [22:0] mod_addr;
  logic mod_wr, mod_rst_n, pwr_ok, strap_mem_en;
  logic [2*NS-1:0] mod_irq_n;
  logic [31:0] q, cap_d;
  logic [NS-1:0] cap_sel;
  logic [1:0] cap_sp;
  logic [22:0] cap_a;
  logic [3:0] cap_be;
  logic e, rt, cap_wr;
  int n_errors, cmp_count, cyc, clk0, clk1, n;

  ipc_bridge #(.NSLOT(NS), .TMO_CYC(20), .MRST_CYC(MRST)) dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hst_req(hst_req), .hst_wr(hst_wr), .hst_bar(hst_bar), .hst_addr(hst_addr),
    .hst_be(hst_be), .hst_wdata(hst_wdata), .hst_done(hst_done), .hst_retry(hst_retry), .hst_rdata(hst_rdata),
    .inta_o(inta_o), .inta_oe_n(inta_oe_n), .mod_sel(mod_sel), .mod_space(mod_space), .mod_addr(mod_addr),
    .mod_be(mod_be), .mod_wr(mod_wr), .mod_wdata(mod_wdata), .mod_ack(mod_ack), .mod_rdata(mod_rdata),
    .mod_clk(mod_clk), .mod_rst_n(mod_rst_n), .mod_irq_n(mod_irq_n), .pwr_ok(pwr_ok),
    .strap_mem_en(strap_mem_en));
  ipc_mod_model #(.NSLOT(NS)) model_u (.clk_sys(clk_sys), .rst(rst), .mod_sel(mod_sel),
    .mod_space(mod_space), .mod_ack(mod_ack), .mod_rdata(mod_rdata));

  // ==========================================
  // Clock, watchdog and shared tasks
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge mod_clk[0]) clk0++;
  always @(posedge mod_clk[1]) clk1++;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, s, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // One host attempt; the request is held until it is answered.
  task automatic hx(input logic w, input logic b, input logic [25:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    hst_req <= 1'b1;
    hst_wr <= w;
    hst_bar <= b;
    hst_addr <= a;
    hst_be <= be;
    hst_wdata <= d;
    do begin
      @(negedge clk_sys);
      if (mod_sel !== '0) begin
        cap_sel = mod_sel;
        cap_sp = mod_space;
        cap_a = mod_addr;
        cap_be = mod_be;
        cap_d = mod_wdata;
        cap_wr = mod_wr;
      end
    end while (hst_done !== 1'b1 && hst_retry !== 1'b1);
    rt = hst_retry;
    q = hst_rdata;
    @(posedge clk_sys);
    hst_req <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic hrd(input logic b, input logic [25:0] a);
    n = 0;
    do begin
      hx(1'b0, b, a, 4'hf, 32'h0);
      n++;
    end while (rt === 1'b1 && n < 200);
    chk("read repeats ended", {31'h0, rt}, 32'h0);
  endtask
  task automatic inta_is(input logic exp);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("inta", {31'h0, inta_oe_n}, {31'h0, exp});
    chk("inta level", {31'h0, inta_o}, 32'h0);
    @(posedge clk_sys);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("rst_n low", {31'h0, mod_rst_n}, 32'h0);
    repeat (MRST + 1) @(posedge clk_sys);
    chk("rst_n high", {31'h0, mod_rst_n}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset reg", q, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("info", q & 32'h0f01, 32'h0501);
    apb(1'b1, 8'h40, 32'h1);
    chk("unmapped err", {31'h0, e}, 32'h1);
  endtask
  task automatic t_writes();
    logic [3:0] bes [4] = '{4'h1, 4'hc, 4'hf, 4'h2};
    for (int sp = 0; sp < 4; sp++) begin
      hx(1'b1, sp == 3, (sp == 3) ? {3'h2, 23'h1000} : {15'h0, 3'h0, 2'(sp), 6'h04}, bes[sp], 32'h5a00_0000 + sp);
      chk("wr done", {31'h0, rt}, 32'h0);
      chk("sel", 32'(cap_sel), (sp == 3) ? 32'h4 : 32'h1);
      chk("space", 32'(cap_sp), 32'(sp));
      chk("addr", 32'(cap_a), (sp == 3) ? 32'h1000 : 32'h4);
      chk("be", 32'(cap_be), 32'(bes[sp]));
      chk("wdata", cap_d, 32'h5a00_0000 + sp);
      chk("wr dir", {31'h0, cap_wr}, 32'h1);
    end
    cap_sel = '0;
    hx(1'b1, 1'b0, 26'h004, 4'h5, 32'h0);
    chk("bad be no cycle", 32'(cap_sel), 32'h0);
  endtask
  task automatic t_read();
    hrd(1'b0, 26'h150);
    chk("early repeats retried", {31'h0, n > 2}, 32'h1);
    chk("read data", q, 32'hc0de_0011);
    apb(1'b0, 8'h04, 32'h0);
    chk("stat ready", q, 32'h2);
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    chk("stat cleared", q, 32'h0);
  endtask
  task automatic t_timeout();
    hrd(1'b0, 26'h400);
    chk("empty slot data", q, 32'hffff_ffff);
    apb(1'b0, 8'h04, 32'h0);
    chk("tmo flag", q, 32'h3);
    inta_is(1'b1);
    apb(1'b1, 8'h08, 32'h1);
    inta_is(1'b0);
    apb(1'b1, 8'h04, 32'h3);
    inta_is(1'b1);
    apb(1'b1, 8'h08, 32'h0);
  endtask
  task automatic t_irq();
    mod_irq_n <= 10'h3f7;
    @(posedge clk_sys);
    apb(1'b0, 8'h0c, 32'h0);
    chk("pending", q, 32'h8);
    apb(1'b1, 8'h00, 32'h1);
    inta_is(1'b1);
    apb(1'b1, 8'h10, 32'h8);
    inta_is(1'b0);
    mod_irq_n <= 10'h3ff;
    inta_is(1'b1);
    apb(1'b1, 8'h10, 32'h0);
  endtask
  task automatic t_clock();
    apb(1'b1, 8'h00, 32'h100);
    repeat (20) @(posedge clk_sys);
    clk0 = 0;
    clk1 = 0;
    repeat (1000) @(posedge clk_sys);
    chk("fast clock", {31'h0, clk0 >= 319 && clk0 <= 321}, 32'h1);
    chk("slow clock", {31'h0, clk1 >= 79 && clk1 <= 81}, 32'h1);
    pwr_ok <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("low supply reset", {31'h0, mod_rst_n}, 32'h0);
    pwr_ok <= 1'b1;
  endtask
  // The strap is only read just after reset, so a second reset is needed to turn memory space off.
  task automatic t_strap();
    strap_mem_en <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("rst_n again", {31'h0, mod_rst_n}, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("strap off", q & 32'h1, 32'h0);
    cap_sel = '0;
    hx(1'b1, 1'b1, {3'h1, 23'h10}, 4'hf, 32'h1);
    chk("mem wr done", {31'h0, rt}, 32'h0);
    chk("mem wr no cycle", 32'(cap_sel), 32'h0);
    hrd(1'b1, {3'h1, 23'h10});
    chk("mem rd dummy", q, 32'hffff_ffff);
  endtask

  initial begin
    {psel, penable, pwrite, hst_req, hst_wr, hst_bar} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hst_addr = 26'h0;
    hst_be = 4'h0;
    hst_wdata = 32'h0;
    mod_irq_n = '1;
    pwr_ok = 1'b1;
    strap_mem_en = 1'b1;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_writes();
    t_read();
    t_timeout();
    t_irq();
    t_clock();
    t_strap();
    stop_test();
  end
endmodule
